// ==== pscl_ctl.sv ====
/*
  Sleep and voltage scaling controller: power state machine, per resource
  on and full-performance selection, core buck voltage codes, event flags
  and the shared interrupt line, plus an AXI4-Lite register slave.
  Assumes all pins are synchronous to aclk and events are level inputs
  whose rising edge counts as one event.
*/
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - each core buck voltage comes from a 7-bit roof or floor code; code zero is off
// - low-power request pin is active low unless polarity is changed
// - with both set-off bits, request low turns both bucks off, high on
// - leaving sleep keeps pre-sleep voltages, or boot voltages when restore bit set
// - resources assigned to an enable pin ignore the low-power request
// - buck a follows enable pin a, buck b pin b, when assigned
// - assigned pin high selects roof voltage code
// - assigned pin low selects floor voltage code
// - floor operation uses light-load pulse-frequency mode by default
// - keep-full bit holds a buck at full performance in floor or sleep
// - by default sleep keeps voltage but reduces transient response
// - keep-full bits keep full load capability during sleep
// - off-select bits switch resources off during sleep
// - no sleep entry while any interrupt is pending
// - supply insertion sets the supply-inserted flag
// - every off to active transition sets power-hold flag
// - button press sets its flag and wakes from off or sleep
// - die nearing temperature limit sets overtemp warning flag
// - low input supply sets low-supply flag
// - gpio event wakes from sleep but never from off
// - low supply raises the shared interrupt line and wakes from sleep, but never from off
// - polarity bit resets to zero, selecting active low request
// - sleep entry needs the sleep-allow bit set
// - mask bits choose which events may wake from sleep or off
module pscl_ctl #(
    parameter logic [6:0] BOOT_SEL_A = pscl_pkg::RST_BOOT_SEL_A,
    parameter logic [6:0] BOOT_SEL_B = pscl_pkg::RST_BOOT_SEL_B
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // control pins
    input wire logic low_power_request,
    input wire logic level_enable_a,
    input wire logic level_enable_b,
    input wire logic power_button_input,
    input wire logic power_keep_input,
    // event sources
    input wire logic supply_inserted,
    input wire logic die_hot,
    input wire logic supply_low,
    input wire logic gpio_event,
    // resource controls
    output logic [pscl_pkg::NUM_RES-1:0] resource_on,
    output logic [pscl_pkg::NUM_RES-1:0] resource_full,
    output logic [6:0] core_buck_a_sel,
    output logic [6:0] core_buck_b_sel,
    // system outputs
    output logic interrupt_out_line,
    output logic system_reset_out_n,
    output logic [1:0] power_state
);
    import pscl_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [2:0] control;
    logic [6:0] buck_a_roof_voltage;
    logic [6:0] buck_b_roof_voltage;
    logic [6:0] buck_a_floor_voltage;
    logic [6:0] buck_b_floor_voltage;
    logic [NUM_RES-1:0] pin_a_assignment;
    logic [NUM_RES-1:0] pin_b_assignment;
    logic [2:0] resource_off_select;
    logic [1:0] regulator_off_select;
    logic [2:0] resource_keep_full_select;
    logic [1:0] regulator_keep_full_select;
    logic [NUM_EV-1:0] event_flags;
    logic [4:0] event_mask_a;
    logic event_mask_b;
    pscl_state_e state;
    pscl_state_e next_state;
    logic [NUM_EV-1:0] event_prev;

    // ----------------------------------------------------------------
    // axi write channel capture
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_lane0 = do_write & w_strb[0];
    wire [7:0] wb = w_data[7:0];

    wire wr_ctl = wr_lane0 & (aw_addr == OFS_CONTROL);
    wire wr_roof_a = wr_lane0 & (aw_addr == OFS_BUCK_A_ROOF);
    wire wr_roof_b = wr_lane0 & (aw_addr == OFS_BUCK_B_ROOF);
    wire wr_floor_a = wr_lane0 & (aw_addr == OFS_BUCK_A_FLOOR);
    wire wr_floor_b = wr_lane0 & (aw_addr == OFS_BUCK_B_FLOOR);
    wire wr_pin_a = wr_lane0 & (aw_addr == OFS_PIN_A_ASSIGN);
    wire wr_pin_b = wr_lane0 & (aw_addr == OFS_PIN_B_ASSIGN);
    wire wr_res_off = wr_lane0 & (aw_addr == OFS_RES_OFF);
    wire wr_reg_off = wr_lane0 & (aw_addr == OFS_REG_OFF);
    wire wr_res_keep = wr_lane0 & (aw_addr == OFS_RES_KEEP);
    wire wr_reg_keep = wr_lane0 & (aw_addr == OFS_REG_KEEP);
    wire wr_flags = wr_lane0 & (aw_addr == OFS_EVENT_FLAGS);
    wire wr_mask_a = wr_lane0 & (aw_addr == OFS_EVENT_MASK_A);
    wire wr_mask_b = wr_lane0 & (aw_addr == OFS_EVENT_MASK_B);
    // status is read-only, so a write to it is refused like a hole
    wire wr_mapped = (aw_addr[1:0] == 2'h0) & (aw_addr < OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~aw_take & ~do_write & ~s_axi_bvalid;
            s_axi_wready <= ~w_held & ~w_take & ~do_write & ~s_axi_bvalid;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    wire sleep_exit = (state == PSCL_SLEEP) & (next_state == PSCL_ACTIVE);
    wire restore_boot = sleep_exit & control[CTL_RESTORE_BOOT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= RST_CONTROL;
            pin_a_assignment <= '0;
            pin_b_assignment <= '0;
            resource_off_select <= 3'h0;
            regulator_off_select <= 2'h0;
            resource_keep_full_select <= 3'h0;
            regulator_keep_full_select <= 2'h0;
            buck_a_floor_voltage <= RST_FLOOR_SEL;
            buck_b_floor_voltage <= RST_FLOOR_SEL;
            event_mask_a <= RST_MASK[4:0];
            event_mask_b <= RST_MASK[5];
        end else begin
            if (wr_ctl) control <= wb[2:0];
            if (wr_pin_a) pin_a_assignment <= wb[NUM_RES-1:0];
            if (wr_pin_b) pin_b_assignment <= wb[NUM_RES-1:0];
            if (wr_res_off) resource_off_select <= wb[2:0];
            if (wr_reg_off) regulator_off_select <= wb[1:0];
            if (wr_res_keep) resource_keep_full_select <= wb[2:0];
            if (wr_reg_keep) regulator_keep_full_select <= wb[1:0];
            if (wr_floor_a) buck_a_floor_voltage <= wb[6:0];
            if (wr_floor_b) buck_b_floor_voltage <= wb[6:0];
            if (wr_mask_a) event_mask_a <= wb[4:0];
            if (wr_mask_b) event_mask_b <= wb[0];
        end
    end

    // roof codes are left alone across sleep unless boot restore is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buck_a_roof_voltage <= BOOT_SEL_A;
            buck_b_roof_voltage <= BOOT_SEL_B;
        end else if (restore_boot) begin
            buck_a_roof_voltage <= BOOT_SEL_A;
            buck_b_roof_voltage <= BOOT_SEL_B;
        end else begin
            if (wr_roof_a) buck_a_roof_voltage <= wb[6:0];
            if (wr_roof_b) buck_b_roof_voltage <= wb[6:0];
        end
    end

    // ----------------------------------------------------------------
    // events and flags
    // ----------------------------------------------------------------
    wire off_to_active = (state == PSCL_OFF) & (next_state == PSCL_ACTIVE);
    wire [NUM_EV-1:0] event_level = {gpio_event, supply_low, die_hot, power_button_input, 1'b0, supply_inserted};
    wire [NUM_EV-1:0] event_rise = event_level & ~event_prev;
    wire [NUM_EV-1:0] flag_set = {event_rise[5:2], off_to_active, event_rise[0]};
    wire [NUM_EV-1:0] flag_clr = wr_flags ? wb[NUM_EV-1:0] : '0;
    wire [NUM_EV-1:0] ev_mask = {event_mask_b, event_mask_a};
    // a set mask bit keeps its event from the line and from waking
    wire [NUM_EV-1:0] ev_live = ~ev_mask;
    wire irq_pending = |(event_flags & ev_live);
    wire [NUM_EV-1:0] wake_new = event_rise & ev_live;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_prev <= '0;
            event_flags <= '0;
        end else begin
            event_prev <= event_level;
            // an event landing on its own clear survives
            event_flags <= (event_flags & ~flag_clr) | flag_set;
        end
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    wire polarity = control[CTL_POLARITY];
    wire sleep_req = polarity ? low_power_request : ~low_power_request;
    wire off_wake = wake_new[EV_BUTTON] | wake_new[EV_SUPPLY];
    wire sleep_wake = |wake_new;
    wire sleep_go = sleep_req & control[CTL_SLEEP_ALLOW] & ~irq_pending;

    always_comb begin
        next_state = state;
        unique case (state)
            PSCL_OFF: begin
                if (off_wake) next_state = PSCL_ACTIVE;
            end
            PSCL_ACTIVE: begin
                if (!power_keep_input) next_state = PSCL_OFF;
                else if (sleep_go) next_state = PSCL_SLEEP;
            end
            PSCL_SLEEP: begin
                if (!power_keep_input) next_state = PSCL_OFF;
                else if (!sleep_req || sleep_wake) next_state = PSCL_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state <= PSCL_OFF;
        else state <= next_state;
    end

    // ----------------------------------------------------------------
    // resource selection
    // ----------------------------------------------------------------
    wire powered = (state != PSCL_OFF);
    wire asleep = (state == PSCL_SLEEP);
    wire [NUM_RES-1:0] off_sel = {regulator_off_select, resource_off_select};
    wire [NUM_RES-1:0] keep_sel = {regulator_keep_full_select, resource_keep_full_select};
    wire [NUM_RES-1:0] by_pin = pin_a_assignment | pin_b_assignment;
    wire [NUM_RES-1:0] pin_high;
    wire [NUM_RES-1:0] next_on;
    wire [NUM_RES-1:0] next_full;
    // pin a takes precedence when software assigns a resource to both
    wire buck_a_by_pin = by_pin[RES_BUCK_A];
    wire buck_b_by_pin = by_pin[RES_BUCK_B];
    wire [6:0] next_sel_a = (buck_a_by_pin & ~pin_high[RES_BUCK_A]) ?
                            buck_a_floor_voltage : buck_a_roof_voltage;
    wire [6:0] next_sel_b = (buck_b_by_pin & ~pin_high[RES_BUCK_B]) ?
                            buck_b_floor_voltage : buck_b_roof_voltage;
    wire sel_a_live = (next_sel_a != SEL_OFF);
    wire sel_b_live = (next_sel_b != SEL_OFF);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_RES; gi++) begin : g_res
            logic code_live;
            if (gi == RES_BUCK_A) begin : g_a
                assign code_live = sel_a_live;
            end else if (gi == RES_BUCK_B) begin : g_b
                assign code_live = sel_b_live;
            end else begin : g_other
                assign code_live = 1'b1;
            end
            assign pin_high[gi] = pin_a_assignment[gi] ? level_enable_a : level_enable_b;
            // pin-controlled resources never see the sleep request
            assign next_on[gi] = powered & code_live &
                                 (by_pin[gi] | ~(asleep & off_sel[gi]));
            // floor level or sleep drops to light load unless kept full
            assign next_full[gi] = by_pin[gi] ? (pin_high[gi] | keep_sel[gi]) :
                                   (~asleep | keep_sel[gi]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resource_on <= '0;
            resource_full <= '0;
            core_buck_a_sel <= SEL_OFF;
            core_buck_b_sel <= SEL_OFF;
            interrupt_out_line <= 1'b0;
            system_reset_out_n <= 1'b0;
            power_state <= 2'h0;
        end else begin
            resource_on <= next_on;
            resource_full <= next_full & next_on;
            core_buck_a_sel <= next_on[RES_BUCK_A] ? next_sel_a : SEL_OFF;
            core_buck_b_sel <= next_on[RES_BUCK_B] ? next_sel_b : SEL_OFF;
            interrupt_out_line <= irq_pending;
            system_reset_out_n <= powered;
            power_state <= state;
        end
    end

    // ----------------------------------------------------------------
    // axi read
    // ----------------------------------------------------------------
    wire ar_take = s_axi_arvalid & s_axi_arready;
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CONTROL: rd_word[2:0] = control;
            OFS_BUCK_A_ROOF: rd_word[6:0] = buck_a_roof_voltage;
            OFS_BUCK_B_ROOF: rd_word[6:0] = buck_b_roof_voltage;
            OFS_BUCK_A_FLOOR: rd_word[6:0] = buck_a_floor_voltage;
            OFS_BUCK_B_FLOOR: rd_word[6:0] = buck_b_floor_voltage;
            OFS_PIN_A_ASSIGN: rd_word[NUM_RES-1:0] = pin_a_assignment;
            OFS_PIN_B_ASSIGN: rd_word[NUM_RES-1:0] = pin_b_assignment;
            OFS_RES_OFF: rd_word[2:0] = resource_off_select;
            OFS_REG_OFF: rd_word[1:0] = regulator_off_select;
            OFS_RES_KEEP: rd_word[2:0] = resource_keep_full_select;
            OFS_REG_KEEP: rd_word[1:0] = regulator_keep_full_select;
            OFS_EVENT_FLAGS: rd_word[NUM_EV-1:0] = event_flags;
            OFS_EVENT_MASK_A: rd_word[4:0] = event_mask_a;
            OFS_EVENT_MASK_B: rd_word[0] = event_mask_b;
            OFS_STATUS: rd_word[15:0] = {core_buck_b_sel, core_buck_a_sel, state};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== pscl_pkg.sv ====
/*
  Constants for the sleep and voltage scaling control block: register byte
  offsets, field positions, reset values and the power state enumeration.
  Assumes a 32-bit AXI4-Lite register bus with word aligned registers.
*/
`default_nettype none

package pscl_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_BUCK_A_ROOF = 8'h04;
    localparam logic [7:0] OFS_BUCK_B_ROOF = 8'h08;
    localparam logic [7:0] OFS_BUCK_A_FLOOR = 8'h0c;
    localparam logic [7:0] OFS_BUCK_B_FLOOR = 8'h10;
    localparam logic [7:0] OFS_PIN_A_ASSIGN = 8'h14;
    localparam logic [7:0] OFS_PIN_B_ASSIGN = 8'h18;
    localparam logic [7:0] OFS_RES_OFF = 8'h1c;
    localparam logic [7:0] OFS_REG_OFF = 8'h20;
    localparam logic [7:0] OFS_RES_KEEP = 8'h24;
    localparam logic [7:0] OFS_REG_KEEP = 8'h28;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h2c;
    localparam logic [7:0] OFS_EVENT_MASK_A = 8'h30;
    localparam logic [7:0] OFS_EVENT_MASK_B = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTL_POLARITY = 0;
    localparam int CTL_SLEEP_ALLOW = 1;
    localparam int CTL_RESTORE_BOOT = 2;

    // resource index: buck a, buck b, io buck (resource group)
    localparam int RES_BUCK_A = 0;
    localparam int RES_BUCK_B = 1;
    localparam int RES_IO = 2;
    // regulators follow at index 3 and 4 (regulator group)
    localparam int RES_AUX_A = 3;
    localparam int RES_AUX_HIGH = 4;
    localparam int NUM_RES = 5;

    // event flag bits
    localparam int EV_SUPPLY = 0;
    localparam int EV_HOLD = 1;
    localparam int EV_BUTTON = 2;
    localparam int EV_HOT = 3;
    localparam int EV_LOW = 4;
    localparam int EV_GPIO = 5;
    localparam int NUM_EV = 6;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] RST_CONTROL = 3'h0;
    localparam logic [6:0] RST_BOOT_SEL_A = 7'h30;
    localparam logic [6:0] RST_BOOT_SEL_B = 7'h28;
    localparam logic [6:0] RST_FLOOR_SEL = 7'h20;
    localparam logic [6:0] SEL_OFF = 7'h00;
    localparam logic [5:0] RST_MASK = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PSCL_OFF,
        PSCL_ACTIVE,
        PSCL_SLEEP
    } pscl_state_e;

endpackage

`default_nettype wire

// ==== pscl_chk_properties.sv ====
/*
  Port checker for pscl_ctl, bound to every instance.
  Assumes one clock, aclk, and synchronous active-low aresetn.
*/
`timescale 1ns/10ps
`default_nettype none
module pscl_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // power outputs
    input wire logic [4:0] resource_on,
    input wire logic [6:0] core_buck_a_sel,
    input wire logic interrupt_out_line,
    input wire logic system_reset_out_n,
    input wire logic [1:0] power_state
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_off_dark: assert property (power_state == 2'h0 |-> resource_on == 5'h00)
        else $error("resource on while off");
    chk_reset_out: assert property (system_reset_out_n == (power_state != 2'h0))
        else $error("reset out disagrees with state");
    chk_code_off: assert property (!resource_on[0] |-> core_buck_a_sel == 7'h00)
        else $error("buck a code while off");
    // sleep may start only from a quiet line
    chk_sleep_quiet: assert property ($rose(power_state == 2'h2) |-> !$past(interrupt_out_line))
        else $error("sleep with pending event");
    // only a register write can drop the line
    chk_line_held: assert property ($fell(interrupt_out_line) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("line dropped without write");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken with response pending");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken with read pending");
    cover property (power_state == 2'h2);
    cover property ($rose(interrupt_out_line));
    cover property ($fell(resource_on[0]));
endmodule
bind pscl_ctl pscl_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .resource_on, .core_buck_a_sel, .interrupt_out_line,
    .system_reset_out_n, .power_state);
`default_nettype wire

// ==== pscl_proc_model.sv ====
/*
  Processor model: AXI4-Lite master tasks, one transfer at a time.
  Assumes aclk from the bench; ready signals come from pscl_ctl.
*/
`timescale 1ns/10ps
`default_nettype none
module pscl_proc_model (
    // clock
    input wire logic aclk,
    // write side
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read side
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 1;
        bit w = 1;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (aw || w) begin
            @(posedge aclk);
            aw &= !s_axi_awready;
            w &= !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        // released lines must not keep showing the old value
        {s_axi_awaddr, s_axi_wdata} <= {~a, ~d};
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        do @(posedge aclk); while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
  Bench for pscl_ctl: sleep, pins, events, random roof codes.
  Assumes pscl_proc_model as processor and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pscl_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic aclk, aresetn, low_power_request, level_enable_a, level_enable_b, power_button_input;
    logic power_keep_input, supply_inserted, die_hot, supply_low, gpio_event, interrupt_out_line;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, system_reset_out_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_state, r;
    logic [4:0] resource_on, resource_full;
    logic [6:0] core_buck_a_sel, core_buck_b_sel, v;
    int miscompares = 0, comparisons = 0, seed = 47;
    pscl_ctl u_dut (.*);
    pscl_proc_model u_proc (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        u_proc.wr(a, x, r);
        `CHK(r, RESP_OKAY)
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        u_proc.rd(a, d, r);
        `CHK(d, e)
    endtask
    task automatic wait_state(input logic [1:0] s);
        for (int n = 0; n < 40 && power_state !== s; n++) @(posedge aclk);
        `CHK(power_state, s)
    endtask
    function automatic logic [4:0] sleep_on(input logic [4:0] off, pin);
        return ~off | pin;
    endfunction
    task automatic conclude;
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
    initial begin
        {aresetn, level_enable_a, level_enable_b, power_button_input, supply_inserted} = '0;
        {die_hot, supply_low, gpio_event, low_power_request, power_keep_input} = 5'h03;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rdc(OFS_CONTROL, 32'h0);
        rdc(OFS_BUCK_A_ROOF, 32'h30);
        u_proc.rd(8'h3c, d, r);
        `CHK({d, r}, {32'h0, RESP_SLVERR})
        supply_inserted <= 1;
        wait_state(2'h1);
        rdc(OFS_EVENT_FLAGS, 32'h3);
        `CHK(interrupt_out_line, 1'b1)
        wr(OFS_CONTROL, 32'h2);
        low_power_request <= 0;
        repeat (20) @(posedge aclk);
        `CHK(power_state, 2'h1)
        wr(OFS_EVENT_FLAGS, 32'h3f);
        wait_state(2'h2);
        `CHK({resource_on, resource_full}, 10'h3e0)
        low_power_request <= 1;
        wait_state(2'h1);
        wr(OFS_RES_OFF, 32'h3);
        wr(OFS_REG_OFF, 32'h1);
        wr(OFS_RES_KEEP, 32'h6);
        // odd passes set the restore bit, even passes keep the written code
        for (int i = 0; i < 4; i++) begin
            v = {1'b1, 6'($random(seed))};
            wr(OFS_BUCK_A_ROOF, {25'h0, v});
            wr(OFS_CONTROL, i[0] ? 32'h6 : 32'h2);
            `CHK(core_buck_a_sel, v)
            low_power_request <= 0;
            wait_state(2'h2);
            `CHK(resource_on, sleep_on(5'h0b, 5'h00))
            `CHK(resource_full & resource_on, 5'h04)
            low_power_request <= 1;
            wait_state(2'h1);
            repeat (2) @(posedge aclk);
            `CHK(core_buck_a_sel, i[0] ? 7'h30 : v)
        end
        wr(OFS_PIN_A_ASSIGN, 32'h1);
        wr(OFS_PIN_B_ASSIGN, 32'h2);
        @(posedge aclk);
        `CHK({core_buck_a_sel, core_buck_b_sel}, 14'h1020)
        `CHK(resource_full[1:0], 2'h2)
        level_enable_a <= 1;
        repeat (3) @(posedge aclk);
        `CHK(core_buck_a_sel, 7'h30)
        low_power_request <= 0;
        wait_state(2'h2);
        `CHK(resource_on, sleep_on(5'h0b, 5'h03))
        gpio_event <= 1;
        wait_state(2'h1);
        {die_hot, supply_low} <= 2'h3;
        rdc(OFS_EVENT_FLAGS, 32'h38);
        wr(OFS_EVENT_MASK_A, 32'h18);
        wr(OFS_EVENT_MASK_B, 32'h1);
        wait_state(2'h2);
        `CHK(interrupt_out_line, 1'b0)
        gpio_event <= 0;
        power_keep_input <= 0;
        wait_state(2'h0);
        wr(OFS_EVENT_MASK_B, 32'h0);
        {gpio_event, power_keep_input} <= 2'h3;
        repeat (20) @(posedge aclk);
        `CHK(power_state, 2'h0)
        power_button_input <= 1;
        wait_state(2'h1);
        rdc(OFS_EVENT_FLAGS, 32'h3e);
        conclude();
    end
endmodule
`default_nettype wire
